// file: ssm_regs.vh
// Register map, field positions and reset values for the SSM event logic
//
// Notes on behaviour
// - Bit 7 sets when received message equals match three after filter validation.
// - Bit 6 sets when received message equals match two after filter validation.
// - Bit 1 sets when received message equals match one after filter validation.
// - Bit 3 sets on every valid received message, filter not required.
// - Bit 2 sets once transmit message sent the programmed repetition count, or after one send if the count is zero.
// - Bit 0 sets when the filtered received message changes value.
// - Event status bits 5 and 4 reserved; all status and enable reset zero.
// - Each event enable bit gates its same-position event onto the interrupt.
// - Unstable bit 6 sets when a valid message differs from previous value.
// - Unstable event waits for a first valid message since start.
// - Reading the unstable status register clears it.
// - Unstable enable bit 6 gates the unstable event; other bits reserved.
`ifndef SSM_REGS_VH
`define SSM_REGS_VH

// ----------------------------------------------------------------
// Byte offsets on the APB
// ----------------------------------------------------------------
`define SSM_OFS_EVT_STAT   8'h00
`define SSM_OFS_EVT_EN     8'h04
`define SSM_OFS_UNST_STAT  8'h08
`define SSM_OFS_UNST_EN    8'h0c
`define SSM_OFS_MATCH1     8'h10
`define SSM_OFS_MATCH2     8'h14
`define SSM_OFS_MATCH3     8'h18
`define SSM_OFS_RX_MSG     8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSM_BIT_MATCH3     7
`define SSM_BIT_MATCH2     6
`define SSM_BIT_FULL       3
`define SSM_BIT_EMPTY      2
`define SSM_BIT_MATCH1     1
`define SSM_BIT_CHANGE     0
`define SSM_BIT_UNSTABLE   6
`define SSM_EVT_MASK       8'hcf
`define SSM_UNST_MASK      8'h40

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSM_RST_REG        8'h00
`define SSM_RST_MSG        6'h00

`endif

// file: ssm_sticky_bits.v
// Sticky clear-on-read status bits with enable gating
`timescale 1ns/1ps
module ssm_sticky_bits #(
  parameter WIDTH = 8
) (
  input  wire             clock,      // System clock
  input  wire             rst,        // Async reset, high
  input  wire [WIDTH-1:0] setPulse,   // Event pulses
  input  wire             clearRead,  // Read of status
  input  wire [WIDTH-1:0] enableBits, // Enable register
  output wire [WIDTH-1:0] statusBits, // Sticky status
  output wire             anyPending  // Status and enable
);

  reg [WIDTH-1:0] status_reg;

  // ----------------------------------------------------------------
  // Per-bit flag, set beats clear so no event is lost
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          status_reg[i] <= 1'b0;
        end else if (setPulse[i]) begin
          status_reg[i] <= 1'b1;
        end else if (clearRead) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign statusBits = status_reg;
  // Level request while any enabled bit pends
  assign anyPending = |(status_reg & enableBits);

endmodule

// file: ssm_tx_repeat.v
// Counts transmitted message repetitions and flags completion
`timescale 1ns/1ps
module ssm_tx_repeat #(
  parameter CW = 8
) (
  input  wire          clock,       // System clock
  input  wire          rst,         // Async reset, high
  input  wire          txLoad,      // New message loaded
  input  wire [CW-1:0] txRepeats,   // Programmed repetitions
  input  wire          txSent,      // One repetition sent
  output reg           txEmptyPulse // All repetitions done
);

  reg [CW-1:0] count_reg;
  reg          busy_reg;

  // ----------------------------------------------------------------
  // Repetition counter; a reload restarts the count
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg    <= {CW{1'b0}};
      busy_reg     <= 1'b0;
      txEmptyPulse <= 1'b0;
    end else begin
      txEmptyPulse <= 1'b0;
      if (txLoad) begin
        count_reg <= {CW{1'b0}};
        busy_reg  <= 1'b1;
      end else if (busy_reg && txSent) begin
        if (count_reg + {{(CW-1){1'b0}}, 1'b1} >= txRepeats) begin
          busy_reg     <= 1'b0;
          txEmptyPulse <= 1'b1;
        end
        count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// file: ssm_message_event_logic.v
// Per-channel SSM event detection, status and enable registers, APB slave
`timescale 1ns/1ps
`include "ssm_regs.vh"
module ssm_message_event_logic #(
  parameter MW = 6,   // Message width
  parameter CW = 8    // Repetition count width
) (
  input  wire          clock,          // 100 MHz clock
  input  wire          rst,            // Async reset, high
  input  wire          psel,           // APB select
  input  wire          penable,        // APB enable
  input  wire          pwrite,         // APB direction
  input  wire [7:0]    paddr,          // APB byte address
  input  wire [31:0]   pwdata,         // APB write data
  output wire          pready,         // APB ready
  output reg  [31:0]   prdata,         // APB read data
  output wire          pslverr,        // APB error
  input  wire          rxMsgValid,     // Valid message extracted
  input  wire [MW-1:0] rxMsg,          // Extracted message
  input  wire          rxFilterOk,     // Filter criterion met
  input  wire          txLoad,         // Transmit message loaded
  input  wire [CW-1:0] txRepeats,      // Programmed repetitions
  input  wire          txSent,         // One repetition sent
  output wire          irq             // Channel interrupt, high
);

  reg  [7:0]    evtEn_reg;
  reg  [7:0]    unstEn_reg;
  reg  [MW-1:0] match1_reg;
  reg  [MW-1:0] match2_reg;
  reg  [MW-1:0] match3_reg;
  reg  [MW-1:0] rxHold_reg;     // Last filtered message
  reg  [MW-1:0] lastValid_reg;  // Last valid message
  reg           seenValid_reg;
  reg           seenFiltered_reg;
  reg  [7:0]    evtSet;
  reg  [7:0]    unstSet;
  reg  [31:0]   readData;
  wire [7:0]    evtStatus;
  wire [7:0]    unstStatus;
  wire          evtPend;
  wire          unstPend;
  wire          txEmptyPulse;
  wire          access;
  wire          wrAcc;
  wire          rdAcc;
  wire          mapped;
  wire          filtEvt;
  wire          evtClr;
  wire          unstClr;
  wire [7:0]    evtKeep;
  wire [7:0]    unstKeep;

  // ----------------------------------------------------------------
  // APB slave: zero-wait, unmapped gives error
  // ----------------------------------------------------------------
  assign access = psel & penable;
  assign wrAcc  = access & pwrite & mapped;
  assign rdAcc  = access & ~pwrite & mapped;
  assign pready = 1'b1;
  assign mapped = (paddr == `SSM_OFS_EVT_STAT) | (paddr == `SSM_OFS_EVT_EN) |
                  (paddr == `SSM_OFS_UNST_STAT) | (paddr == `SSM_OFS_UNST_EN) |
                  (paddr == `SSM_OFS_MATCH1) | (paddr == `SSM_OFS_MATCH2) |
                  (paddr == `SSM_OFS_MATCH3) | (paddr == `SSM_OFS_RX_MSG);
  assign pslverr = access & ~mapped;

  // Writable registers; reserved enable bits are forced to zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      evtEn_reg  <= `SSM_RST_REG;
      unstEn_reg <= `SSM_RST_REG;
      match1_reg <= `SSM_RST_MSG;
      match2_reg <= `SSM_RST_MSG;
      match3_reg <= `SSM_RST_MSG;
    end else if (wrAcc) begin
      case (paddr)
        `SSM_OFS_EVT_EN:  evtEn_reg  <= pwdata[7:0] & `SSM_EVT_MASK;
        `SSM_OFS_UNST_EN: unstEn_reg <= pwdata[7:0] & `SSM_UNST_MASK;
        `SSM_OFS_MATCH1:  match1_reg <= pwdata[MW-1:0];
        `SSM_OFS_MATCH2:  match2_reg <= pwdata[MW-1:0];
        `SSM_OFS_MATCH3:  match3_reg <= pwdata[MW-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; narrow registers sit in the low bits
  always @* begin
    readData = 32'h00000000;
    case (paddr)
      `SSM_OFS_EVT_STAT:  readData[7:0]    = evtStatus;
      `SSM_OFS_EVT_EN:    readData[7:0]    = evtEn_reg;
      `SSM_OFS_UNST_STAT: readData[7:0]    = unstStatus;
      `SSM_OFS_UNST_EN:   readData[7:0]    = unstEn_reg;
      `SSM_OFS_MATCH1:    readData[MW-1:0] = match1_reg;
      `SSM_OFS_MATCH2:    readData[MW-1:0] = match2_reg;
      `SSM_OFS_MATCH3:    readData[MW-1:0] = match3_reg;
      `SSM_OFS_RX_MSG:    readData[MW-1:0] = rxHold_reg;
      default:            readData         = 32'h00000000;
    endcase
  end

  // Read data registered so it never glitches between accesses
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= readData;
    end
  end

  // ----------------------------------------------------------------
  // Receive message tracking
  // ----------------------------------------------------------------
  assign filtEvt = rxMsgValid & rxFilterOk;

  // Holder of the filtered message and of the last valid one
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rxHold_reg       <= `SSM_RST_MSG;
      lastValid_reg    <= `SSM_RST_MSG;
      seenValid_reg    <= 1'b0;
      seenFiltered_reg <= 1'b0;
    end else begin
      if (rxMsgValid) begin
        lastValid_reg <= rxMsg;
        seenValid_reg <= 1'b1;
      end
      if (filtEvt) begin
        rxHold_reg       <= rxMsg;
        seenFiltered_reg <= 1'b1;
      end
    end
  end

  // Event pulses; first filtered message counts as a change
  always @* begin
    evtSet  = 8'h00;
    unstSet = 8'h00;
    evtSet[`SSM_BIT_MATCH3] = filtEvt & (rxMsg == match3_reg);
    evtSet[`SSM_BIT_MATCH2] = filtEvt & (rxMsg == match2_reg);
    evtSet[`SSM_BIT_MATCH1] = filtEvt & (rxMsg == match1_reg);
    evtSet[`SSM_BIT_FULL]   = rxMsgValid;
    evtSet[`SSM_BIT_EMPTY]  = txEmptyPulse;
    evtSet[`SSM_BIT_CHANGE] = filtEvt & (~seenFiltered_reg | (rxMsg != rxHold_reg));
    // Unstable only after a first valid message was seen
    unstSet[`SSM_BIT_UNSTABLE] = rxMsgValid & seenValid_reg & (rxMsg != lastValid_reg);
  end

  // ----------------------------------------------------------------
  // Transmit completion and status banks
  // ----------------------------------------------------------------
  ssm_tx_repeat #(
    .CW (CW)
  ) uTxRepeat (
    .clock        (clock),
    .rst          (rst),
    .txLoad       (txLoad),
    .txRepeats    (txRepeats),
    .txSent       (txSent),
    .txEmptyPulse (txEmptyPulse)
  );

  // Read data is captured in the setup cycle, so a flag set on that edge
  // is not in prdata; it is re-set on the clearing edge to survive the read
  assign evtClr   = rdAcc & (paddr == `SSM_OFS_EVT_STAT);
  assign unstClr  = rdAcc & (paddr == `SSM_OFS_UNST_STAT);
  assign evtKeep  = evtStatus & ~prdata[7:0] & {8{evtClr}};
  assign unstKeep = unstStatus & ~prdata[7:0] & {8{unstClr}};

  // Reserved bits never set, so they read zero
  ssm_sticky_bits #(
    .WIDTH (8)
  ) uEvtStatus (
    .clock      (clock),
    .rst        (rst),
    .setPulse   ((evtSet & `SSM_EVT_MASK) | evtKeep),
    .clearRead  (evtClr),
    .enableBits (evtEn_reg),
    .statusBits (evtStatus),
    .anyPending (evtPend)
  );

  ssm_sticky_bits #(
    .WIDTH (8)
  ) uUnstStatus (
    .clock      (clock),
    .rst        (rst),
    .setPulse   (unstSet | unstKeep),
    .clearRead  (unstClr),
    .enableBits (unstEn_reg),
    .statusBits (unstStatus),
    .anyPending (unstPend)
  );

  // One level request for the channel
  assign irq = evtPend | unstPend;

endmodule

// file: ssm_framer_model.sv
// Framer-side model: delivers received messages and transmit completions
`timescale 1ns/1ps
module ssm_framer_model (
  output reg       rxMsgValid = 1'b0, // Rx strobe
  output reg [5:0] rxMsg      = 6'h2a, // Rx message
  output reg       rxFilterOk = 1'b0, // Filter met
  output reg       txLoad     = 1'b0, // Tx load
  output reg [7:0] txRepeats  = 8'h00, // Tx count
  output reg       txSent     = 1'b0, // Tx sent
  input  wire      clock               // Clock
);
  // One message; lines show the inverse once released so no stale match
  task rx(input logic [5:0] m, input logic f);
    begin
      @(posedge clock);
      rxMsgValid <= 1'b1;
      rxMsg      <= m;
      rxFilterOk <= f;
      @(posedge clock);
      rxMsgValid <= 1'b0;
      rxMsg      <= ~m;
      rxFilterOk <= ~f;
    end
  endtask
  // Load pulse or one sent repetition
  task tx(input logic load, input logic [7:0] r);
    begin
      @(posedge clock);
      txLoad    <= load;
      txSent    <= ~load;
      txRepeats <= r;
      @(posedge clock);
      txLoad <= 1'b0;
      txSent <= 1'b0;
    end
  endtask
endmodule

// file: ssm_message_event_logic_chk.sv
// Port assertions for the SSM event logic
`timescale 1ns/1ps
module ssm_message_event_logic_chk #(
  parameter MW = 6,
  parameter CW = 8
) (
  input wire          clock,      // Clock
  input wire          rst,        // Reset
  input wire          psel,       // Select
  input wire          penable,    // Enable
  input wire          pwrite,     // Write
  input wire [7:0]    paddr,      // Address
  input wire [31:0]   pwdata,     // Wdata
  input wire          pready,     // Ready
  input wire [31:0]   prdata,     // Rdata
  input wire          pslverr,    // Error
  input wire          rxMsgValid, // Rx strobe
  input wire [MW-1:0] rxMsg,      // Rx message
  input wire          rxFilterOk, // Filter
  input wire          txLoad,     // Tx load
  input wire [CW-1:0] txRepeats,  // Tx count
  input wire          txSent,     // Tx sent
  input wire          irq         // Interrupt
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire      acc    = psel && penable;
  wire      mapped = paddr[1:0] == 2'h0 && paddr <= 8'h1c;
  reg [3:0] quietCnt;
  // Cycles without events; a clear is only judged once nothing is in flight
  always @(posedge clock or posedge rst) begin
    if (rst)
      quietCnt <= 4'h0;
    else if (rxMsgValid || txSent)
      quietCnt <= 4'h0;
    else if (quietCnt != 4'hf)
      quietCnt <= quietCnt + 4'h1;
  end
  sequence rdAt(logic [7:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  sequence rdAgain(logic [7:0] a);
    rdAt(a) ##3 (rdAt(a) ##0 quietCnt > 4'h6);
  endsequence
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_unmapped_refuse: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("error on mapped access");
  a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
  a_evt_reserved: assert property (rdAt(8'h00) |-> (prdata & 32'hffffff30) == 32'h0)
    else $error("event status reserved bits set");
  a_unst_reserved: assert property (rdAt(8'h08) |-> (prdata & 32'hffffffbf) == 32'h0)
    else $error("unstable status reserved bits set");
  a_evt_clear: assert property (rdAgain(8'h00) |-> prdata[7:0] == 8'h00)
    else $error("event status kept after read");
  a_unst_clear: assert property (rdAgain(8'h08) |-> prdata[7:0] == 8'h00)
    else $error("unstable status kept after read");
  a_irq_quiet: assert property (!irq && !rxMsgValid && quietCnt > 4'h1 && !(acc && pwrite) |=> !irq)
    else $error("irq rose without cause");
endmodule

// file: tb_ssm_message_event_logic.sv
// Self-checking bench for the SSM event logic
`timescale 1ns/1ps
`include "ssm_regs.vh"
module tb_ssm_message_event_logic;
  reg          clock, rst, psel, penable, pwrite, er, filt, seenV, seenF;
  reg  [7:0]   paddr, en, expE, expU;
  reg  [31:0]  pwdata, rd;
  reg  [5:0]   mt [0:3];
  reg  [5:0]   msg, lastV, lastF;
  wire         pready, pslverr, rxMsgValid, rxFilterOk, txLoad, txSent, irq;
  wire [31:0]  prdata;
  wire [5:0]   rxMsg;
  wire [7:0]   txRepeats;
  integer      fails, checks, seed, i, k;
  ssm_message_event_logic #(.MW(6), .CW(8)) ssm_message_event_logic_inst (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rxMsgValid(rxMsgValid), .rxMsg(rxMsg), .rxFilterOk(rxFilterOk),
    .txLoad(txLoad), .txRepeats(txRepeats), .txSent(txSent), .irq(irq));
  ssm_framer_model ssm_framer_model_inst (.rxMsgValid(rxMsgValid), .rxMsg(rxMsg), .rxFilterOk(rxFilterOk),
    .txLoad(txLoad), .txRepeats(txRepeats), .txSent(txSent), .clock(clock));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task end_of_test;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
        chk(1'b0, 1'b1);
        end_of_test;
      end
    end
  endtask
  // Expected event and unstable flags; advances the message history
  function [7:0] evtOf(input logic [5:0] m, input logic f);
    begin
      evtOf = 8'h08;
      for (k = 1; k < 4; k = k + 1)
        if (f && m == mt[k])
          evtOf = evtOf | (k == 1 ? 8'h02 : k == 2 ? 8'h40 : 8'h80);
      if (f && (!seenF || m != lastF))
        evtOf = evtOf | 8'h01;
      expU  = (seenV && m != lastV) ? 8'h40 : 8'h00;
      seenV = 1'b1;
      lastV = m;
      if (f) begin
        seenF = 1'b1;
        lastF = m;
      end
    end
  endfunction
  initial begin
    {fails, checks, seed} = {32'd0, 32'd0, 32'h905a};
    {rst, psel, penable, pwrite, paddr, pwdata, seenV, seenF} = {4'h8, 40'h0, 2'b00};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, `SSM_OFS_EVT_EN, 32'hff);
    apb(1'b0, `SSM_OFS_EVT_EN, 32'h0);
    chk(rd, 32'hcf);
    apb(1'b1, `SSM_OFS_UNST_EN, 32'hff);
    apb(1'b0, `SSM_OFS_UNST_EN, 32'h0);
    chk(rd, 32'h40);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd}, 33'h100000000);
    for (i = 1; i < 4; i = i + 1) begin
      mt[i] = $random(seed);
      apb(1'b1, 8'(8'h0c + 4 * i), 32'(mt[i]));
      apb(1'b0, 8'(8'h0c + 4 * i), 32'h0);
      chk(rd, 32'(mt[i]));
    end
    // Random traffic with random enables, matches drawn often
    for (i = 0; i < 40; i = i + 1) begin
      en = $random(seed);
      apb(1'b1, `SSM_OFS_EVT_EN, 32'(en));
      apb(1'b1, `SSM_OFS_UNST_EN, 32'(en));
      mt[0] = $random(seed);
      msg   = mt[$random(seed) & 3];
      filt  = $random(seed);
      ssm_framer_model_inst.rx(msg, filt);
      expE = evtOf(msg, filt);
      @(negedge clock);
      chk(irq, |(expE & en & 8'hcf) | |(expU & en & 8'h40));
      apb(1'b0, `SSM_OFS_EVT_STAT, 32'h0);
      chk(rd, 32'(expE));
      apb(1'b0, `SSM_OFS_UNST_STAT, 32'h0);
      chk(rd, 32'(expU));
      @(negedge clock);
      chk(irq, 1'b0);
    end
    // Event on the setup edge, then on the access edge, of a status read
    for (i = 0; i < 2; i = i + 1) begin
      fork
        begin
          repeat (i) @(posedge clock);
          ssm_framer_model_inst.rx(mt[1], 1'b0);
        end
        apb(1'b0, `SSM_OFS_EVT_STAT, 32'h0);
      join
      chk(rd, 32'h0);
      expE = evtOf(mt[1], 1'b0);
      apb(1'b0, `SSM_OFS_EVT_STAT, 32'h0);
      chk(rd, 32'(expE));
      apb(1'b0, `SSM_OFS_UNST_STAT, 32'h0);
      chk(rd, 32'(expU));
    end
    apb(1'b0, `SSM_OFS_RX_MSG, 32'h0);
    chk(rd, seenF ? 32'(lastF) : 32'h0);
    // Repetition counts zero, two and four
    for (i = 0; i < 3; i = i + 1) begin
      ssm_framer_model_inst.tx(1'b1, 8'(2 * i));
      for (k = 1; k < 2 * i; k = k + 1)
        ssm_framer_model_inst.tx(1'b0, 8'(2 * i));
      repeat (3) @(posedge clock);
      apb(1'b0, `SSM_OFS_EVT_STAT, 32'h0);
      chk(rd, 32'h0);
      ssm_framer_model_inst.tx(1'b0, 8'(2 * i));
      repeat (3) @(posedge clock);
      apb(1'b0, `SSM_OFS_EVT_STAT, 32'h0);
      chk(rd, 32'h04);
    end
    for (i = 0; i < 4; i = i + 1)
      apb(1'b0, 8'(i & 2) << 2, 32'h0);
    end_of_test;
  end
endmodule
bind ssm_message_event_logic ssm_message_event_logic_chk #(.MW(MW), .CW(CW)) chk_inst (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .rxMsgValid(rxMsgValid), .rxMsg(rxMsg), .rxFilterOk(rxFilterOk),
  .txLoad(txLoad), .txRepeats(txRepeats), .txSent(txSent), .irq(irq));
